// ===== hdl/cic_regs.sv
// Core identity and configuration register bank with a classic Wishbone slave.
// Assumes wake inputs are synchronous one-cycle or level requests from the core.
// Function
// R1: Revision register is 32 bits and read-only.
// R2: Implementation number bits 15-8, revision bits 7-0, upper bits zero.
// R3: Bits 21-19 report instruction cache size code, read-only.
// R4: Bits 18-16 report data cache size code, read-only.
// R5: Bits 11-10 select slow clock divider ratio, reset 00.
// R6: Writing bit 9 enters doze; pipeline stalls.
// R7: Reset, NMI or interrupt ends doze and clears the bit, even masked.
// R8: Snoops are still serviced during doze.
// R9: Writing bit 8 enters halt; wake events clear it, even masked.
// R10: Snoops are not serviced during halt.
// R11: After lock bit set, later configuration writes are ignored.
// R12: Only reset clears the lock bit.
// R13: The store setting lock still applies its other bits.
// R14: Bit 6 selects burst or single-word data refill.
// R15: Bit 5 enables instruction cache, reset 1.
// R16: Bit 4 enables data cache, reset 1.
// R17: Bits 3-2 select instruction burst length 4/8/16/32 words.
// R18: Bits 1-0 select data burst length, used only when bit 6 is set.
// R19: Bits 31-22 and 15-12 read zero and ignore writes.
// R20: Cache control changes apply after the current bus operation.
// R21: Software never sets doze and halt together.
// R22: Wake resumes the pipeline on the next clock.
`timescale 1ns/1ps
`default_nettype none
module cic_regs #(
	parameter logic [7:0] IMP_NUMBER = 8'h5a, // Arbitrary value.
	parameter logic [7:0] REV_NUMBER = 8'h01, // Arbitrary value.
	parameter logic [2:0] ICACHE_SIZE = cic_pkg::CIC_CSZ_4K,
	parameter logic [2:0] DCACHE_SIZE = cic_pkg::CIC_CSZ_1K
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic nmi_i,
	input wire logic irq_i,
	input wire logic bus_busy_i,
	input wire logic snoop_req_i,
	output logic snoop_ack_o,
	output logic pipeline_stall_o,
	output logic doze_o,
	output logic halt_o,
	output logic [1:0] slow_clock_divider_o,
	output logic icache_on_o,
	output logic dcache_on_o,
	output logic dcache_burst_select_o,
	output logic [1:0] ifetch_burst_length_o,
	output logic [1:0] dfill_burst_length_o
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [1:0] div;
		logic doze;
		logic halt;
		logic lock;
		logic dcache_burst_select;
		logic icache_on;
		logic dce;
		logic [1:0] irs;
		logic [1:0] drs;
		logic [1:0] drs_act;
		logic ack;
		logic err;
		logic [31:0] rdata;
		logic snoop_ack;
	} cic_regs_st_t;

	cic_regs_st_t st_q;
	cic_regs_st_t st_d;
	logic [31:0] cfg_word;
	logic [31:0] rev_word;
	logic [31:0] pwr_word;
	logic [5:0] act;
	logic [5:0] req;
	logic pending;
	logic wake;
	logic access;
	logic wr_cfg;

	// ****************************************************************
	// Read views
	// ****************************************************************
	always_comb begin
		cfg_word = 32'h0000_0000; // R19
		cfg_word[cic_pkg::CIC_CFG_ICS_LSB +: 3] = ICACHE_SIZE; // R3
		cfg_word[cic_pkg::CIC_CFG_DCS_LSB +: 3] = DCACHE_SIZE; // R4
		cfg_word[cic_pkg::CIC_CFG_DIV_LSB +: 2] = st_q.div;
		cfg_word[cic_pkg::CIC_CFG_DOZE_BIT] = st_q.doze;
		cfg_word[cic_pkg::CIC_CFG_HALT_BIT] = st_q.halt;
		cfg_word[cic_pkg::CIC_CFG_LOCK_BIT] = st_q.lock;
		cfg_word[cic_pkg::CIC_CFG_DCACHE_BURST_SELECT_BIT] = st_q.dcache_burst_select;
		cfg_word[cic_pkg::CIC_CFG_ICE_BIT] = st_q.icache_on;
		cfg_word[cic_pkg::CIC_CFG_DCE_BIT] = st_q.dce;
		cfg_word[cic_pkg::CIC_CFG_IRS_LSB +: 2] = st_q.irs;
		cfg_word[cic_pkg::CIC_CFG_DRS_LSB +: 2] = st_q.drs;
	end

	always_comb begin
		rev_word = 32'h0000_0000; // R1
		rev_word[cic_pkg::CIC_REV_IMP_LSB +: 8] = IMP_NUMBER; // R2
		rev_word[cic_pkg::CIC_REV_REV_LSB +: 8] = REV_NUMBER; // R2
	end

	always_comb begin
		pwr_word = 32'h0000_0000;
		pwr_word[cic_pkg::CIC_PWR_STALL_BIT] = pipeline_stall_o;
		pwr_word[cic_pkg::CIC_PWR_SNOOP_BIT] = !st_q.halt;
		pwr_word[cic_pkg::CIC_PWR_BUSY_BIT] = pending;
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Reset is synchronous here, so the reset exception wake is the rst_i branch.
	assign wake = nmi_i || irq_i; // R7
	assign access = wb_cyc_i && wb_stb_i && !st_q.ack && !st_q.err;
	assign wr_cfg = access && wb_we_i && (wb_adr_i == cic_pkg::CIC_IDX_CONFIG);

	always_comb begin
		st_d = st_q;
		st_d.ack = 1'b0;
		st_d.err = 1'b0;
		st_d.snoop_ack = snoop_req_i && !st_q.halt; // R8 R10
		if (access) begin
			case (wb_adr_i)
				cic_pkg::CIC_IDX_CONFIG: begin
					st_d.ack = 1'b1;
					st_d.rdata = cfg_word;
				end
				cic_pkg::CIC_IDX_REVISION: begin
					st_d.ack = 1'b1; // R1
					st_d.rdata = rev_word;
				end
				cic_pkg::CIC_IDX_POWER_STATUS: begin
					st_d.ack = 1'b1;
					st_d.rdata = pwr_word;
				end
				default: begin
					st_d.err = 1'b1;
					st_d.rdata = 32'h0000_0000;
				end
			endcase
		end
		// Writes honour byte lanes; a locked register drops the whole write.
		if (wr_cfg && !st_q.lock) begin // R11
			if (wb_sel_i[1]) begin
				st_d.div = wb_dat_i[cic_pkg::CIC_CFG_DIV_LSB +: 2]; // R5
				st_d.doze = wb_dat_i[cic_pkg::CIC_CFG_DOZE_BIT]; // R6
				st_d.halt = wb_dat_i[cic_pkg::CIC_CFG_HALT_BIT]; // R9
			end
			if (wb_sel_i[0]) begin
				st_d.lock = wb_dat_i[cic_pkg::CIC_CFG_LOCK_BIT]; // R13
				st_d.dcache_burst_select = wb_dat_i[cic_pkg::CIC_CFG_DCACHE_BURST_SELECT_BIT]; // R14
				st_d.icache_on = wb_dat_i[cic_pkg::CIC_CFG_ICE_BIT]; // R15
				st_d.dce = wb_dat_i[cic_pkg::CIC_CFG_DCE_BIT]; // R16
				st_d.irs = wb_dat_i[cic_pkg::CIC_CFG_IRS_LSB +: 2]; // R17
				st_d.drs = wb_dat_i[cic_pkg::CIC_CFG_DRS_LSB +: 2]; // R18
			end
		end
		// A wake event beats a store that would set the mode again.
		if (wake) begin
			st_d.doze = 1'b0; // R7
			st_d.halt = 1'b0; // R9
		end
		// The data burst length waits for the same idle point as the staged controls.
		if (!bus_busy_i) begin
			st_d.drs_act = st_q.drs; // R20
		end
		if (st_q.lock) begin
			st_d.lock = 1'b1; // R12
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '{div: cic_pkg::CIC_RST_DIV, doze: cic_pkg::CIC_RST_DOZE,
				halt: cic_pkg::CIC_RST_HALT, lock: cic_pkg::CIC_RST_LOCK, // R12
				dcache_burst_select: cic_pkg::CIC_RST_DCACHE_BURST_SELECT, icache_on: cic_pkg::CIC_RST_ICE,
				dce: cic_pkg::CIC_RST_DCE, irs: cic_pkg::CIC_RST_IRS,
				drs: cic_pkg::CIC_RST_DRS, drs_act: cic_pkg::CIC_RST_DRS, ack: 1'b0, err: 1'b0,
				rdata: 32'h0000_0000, snoop_ack: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// Cache control staging
	// ****************************************************************
	assign req = {st_q.dcache_burst_select, st_q.icache_on, st_q.dce, st_q.irs, 1'b0};

	cic_cache_cfg_apply u_apply (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.bus_busy_i(bus_busy_i),
		.req_i(req),
		.act_o(act),
		.pending_o(pending)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign wb_dat_o = st_q.rdata;
	assign wb_ack_o = st_q.ack;
	assign wb_err_o = st_q.err;
	assign snoop_ack_o = st_q.snoop_ack;
	// The stall drops in the same cycle that the wake clears the mode bit.
	assign pipeline_stall_o = st_q.doze || st_q.halt; // R6 R22
	assign doze_o = st_q.doze;
	assign halt_o = st_q.halt;
	assign slow_clock_divider_o = st_q.div; // R5
	assign dcache_burst_select_o = act[5]; // R14
	assign icache_on_o = act[4]; // R15
	assign dcache_on_o = act[3]; // R16
	assign ifetch_burst_length_o = act[2:1]; // R17
	// Bit 0 of act is unused padding of the staged vector shape.
	assign dfill_burst_length_o = st_q.drs_act; // R18
endmodule
`default_nettype wire

// ===== hdl/cic_pkg.sv
// Package for the core identity and configuration register bank.
// Assumes a 32-bit classic Wishbone register port with word-indexed registers.
package cic_pkg;
	localparam int unsigned CIC_DW = 32;
	localparam int unsigned CIC_AW = 8;
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] CIC_IDX_CONFIG = 8'h03;
	localparam logic [7:0] CIC_IDX_REVISION = 8'h0f;
	localparam logic [7:0] CIC_IDX_POWER_STATUS = 8'h10;
	// Revision register layout.
	localparam int unsigned CIC_REV_IMP_LSB = 8;
	localparam int unsigned CIC_REV_REV_LSB = 0;
	// Configuration register layout.
	localparam int unsigned CIC_CFG_ICS_LSB = 19;
	localparam int unsigned CIC_CFG_DCS_LSB = 16;
	localparam int unsigned CIC_CFG_DIV_LSB = 10;
	localparam int unsigned CIC_CFG_DOZE_BIT = 9;
	localparam int unsigned CIC_CFG_HALT_BIT = 8;
	localparam int unsigned CIC_CFG_LOCK_BIT = 7;
	localparam int unsigned CIC_CFG_DCACHE_BURST_SELECT_BIT = 6;
	localparam int unsigned CIC_CFG_ICE_BIT = 5;
	localparam int unsigned CIC_CFG_DCE_BIT = 4;
	localparam int unsigned CIC_CFG_IRS_LSB = 2;
	localparam int unsigned CIC_CFG_DRS_LSB = 0;
	// Reset values of the writable fields.
	localparam logic [1:0] CIC_RST_DIV = 2'h0;
	localparam logic CIC_RST_DOZE = 1'b0;
	localparam logic CIC_RST_HALT = 1'b0;
	localparam logic CIC_RST_LOCK = 1'b0;
	localparam logic CIC_RST_DCACHE_BURST_SELECT = 1'b0;
	localparam logic CIC_RST_ICE = 1'b1;
	localparam logic CIC_RST_DCE = 1'b1;
	localparam logic [1:0] CIC_RST_IRS = 2'h0;
	localparam logic [1:0] CIC_RST_DRS = 2'h0;
	// Cache size codes.
	localparam logic [2:0] CIC_CSZ_1K = 3'h0;
	localparam logic [2:0] CIC_CSZ_2K = 3'h1;
	localparam logic [2:0] CIC_CSZ_4K = 3'h2;
	localparam logic [2:0] CIC_CSZ_8K = 3'h3;
	// Power status register bits.
	localparam int unsigned CIC_PWR_STALL_BIT = 0;
	localparam int unsigned CIC_PWR_SNOOP_BIT = 1;
	localparam int unsigned CIC_PWR_BUSY_BIT = 2;
	typedef enum logic [1:0] {
		CIC_RUN,
		CIC_DOZE,
		CIC_HALT
	} cic_pmode_t;
endpackage

// ===== hdl/cic_cache_cfg_apply.sv
// Holds the cache controls the cache datapath uses, except the data burst length.
// Assumes bus_busy_i is high throughout any bus operation such as a refill.
`timescale 1ns/1ps
`default_nettype none
module cic_cache_cfg_apply (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic bus_busy_i,
	input wire logic [5:0] req_i,
	output logic [5:0] act_o,
	output logic pending_o
);
	typedef struct packed {
		logic [5:0] act;
	} cic_apply_st_t;

	cic_apply_st_t st_q;
	cic_apply_st_t st_d;
	// Bit 0 is a spare, so the field positions match the unpacking in the main file.
	localparam logic [5:0] RST_ACT = {cic_pkg::CIC_RST_DCACHE_BURST_SELECT, cic_pkg::CIC_RST_ICE,
		cic_pkg::CIC_RST_DCE, cic_pkg::CIC_RST_IRS, 1'b0};

	// The drs field is held in the main file; here only bits needing staging.
	always_comb begin
		st_d = st_q;
		if (!bus_busy_i) begin
			st_d.act = req_i; // R20
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '{act: RST_ACT};
		end else begin
			st_q <= st_d;
		end
	end

	assign act_o = st_q.act;
	assign pending_o = (st_q.act != req_i);
endmodule
`default_nettype wire

// ===== bench/cic_regs_properties.sv
// Assertion checker for the core identity and configuration register bank.
// Assumes one clock, a synchronous active-high reset and sight of top ports only.
`timescale 1ns/1ps
`default_nettype none
module cic_regs_chk #(
	parameter logic [2:0] ICACHE_SIZE = 3'h0,
	parameter logic [2:0] DCACHE_SIZE = 3'h0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic nmi_i,
	input wire logic irq_i,
	input wire logic bus_busy_i,
	input wire logic snoop_req_i,
	input wire logic snoop_ack_o,
	input wire logic pipeline_stall_o,
	input wire logic doze_o,
	input wire logic halt_o,
	input wire logic icache_on_o,
	input wire logic dcache_on_o,
	input wire logic dcache_burst_select_o,
	input wire logic [1:0] ifetch_burst_length_o,
	input wire logic [1:0] dfill_burst_length_o
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence rd_s(a);
		req_s ##0 (!wb_we_i && wb_adr_i == a);
	endsequence
	bus_answer_a: assert property (req_s |=> wb_ack_o ^ wb_err_o)
		else $error("request not answered once");
	rev_upper_zero_a: assert property (rd_s(8'h0f) |=> wb_dat_o[31:16] == 16'h0)
		else $error("revision upper bits not zero");
	cfg_sizes_a: assert property (rd_s(8'h03) |=>
		wb_dat_o[21:16] == {ICACHE_SIZE, DCACHE_SIZE})
		else $error("cache size codes wrong");
	cfg_zero_bits_a: assert property (rd_s(8'h03) |=>
		{wb_dat_o[31:22], wb_dat_o[15:12]} == 14'h0)
		else $error("reserved config bits not zero");
	stall_mode_a: assert property (pipeline_stall_o == (doze_o || halt_o))
		else $error("stall does not follow power mode");
	stall_cause_a: assert property ($rose(pipeline_stall_o) |->
		$past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h03))
		else $error("stall entered without a config store");
	doze_hold_a: assert property (doze_o && !nmi_i && !irq_i && !(wb_cyc_i && wb_stb_i) |=> doze_o)
		else $error("doze left without cause");
	wake_clear_a: assert property (nmi_i || irq_i |=> !doze_o && !halt_o)
		else $error("wake did not clear power mode");
	doze_snoop_a: assert property (doze_o && snoop_req_i ##1 !halt_o |-> snoop_ack_o)
		else $error("snoop not served in doze");
	halt_snoop_a: assert property (halt_o && $past(halt_o) |-> !snoop_ack_o)
		else $error("snoop served in halt");
	cache_hold_a: assert property ($past(bus_busy_i) |-> $stable({icache_on_o, dcache_on_o,
		dcache_burst_select_o, ifetch_burst_length_o, dfill_burst_length_o}))
		else $error("cache controls changed while busy");
endmodule
bind cic_regs cic_regs_chk #(.ICACHE_SIZE(ICACHE_SIZE), .DCACHE_SIZE(DCACHE_SIZE)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o), .nmi_i(nmi_i), .irq_i(irq_i), .bus_busy_i(bus_busy_i),
	.snoop_req_i(snoop_req_i), .snoop_ack_o(snoop_ack_o), .pipeline_stall_o(pipeline_stall_o),
	.doze_o(doze_o), .halt_o(halt_o), .icache_on_o(icache_on_o), .dcache_on_o(dcache_on_o),
	.dcache_burst_select_o(dcache_burst_select_o),
	.ifetch_burst_length_o(ifetch_burst_length_o),
	.dfill_burst_length_o(dfill_burst_length_o)
);
`default_nettype wire

// ===== bench/cic_regs_tb_top.sv
// Self-checking bench for the core identity and configuration register bank.
// Assumes every register request is answered by ack or err; the watchdog ends a hang.
`timescale 1ns/1ps
`default_nettype none
module cic_regs_tb_top;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic nmi_i = 1'b0, irq_i = 1'b0, bus_busy_i = 1'b0, snoop_req_i = 1'b0, er;
	logic [7:0] wb_adr_i = 8'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic wb_ack_o, wb_err_o, snoop_ack_o, pipeline_stall_o, doze_o, halt_o;
	logic icache_on_o, dcache_on_o, dcache_burst_select_o;
	logic [1:0] slow_clock_divider_o, ifetch_burst_length_o, dfill_burst_length_o;
	int fail_count = 0, samples_checked = 0;
	logic [31:0] rows [3][2] = '{'{32'hffc0fc7f, 32'h00130c7f}, '{32'h0, 32'h00130000},
		'{32'h436, 32'h00130436}};
	cic_regs #(.IMP_NUMBER(8'h3c), .REV_NUMBER(8'h07), .DCACHE_SIZE(cic_pkg::CIC_CSZ_8K)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .nmi_i(nmi_i),
		.irq_i(irq_i), .bus_busy_i(bus_busy_i), .snoop_req_i(snoop_req_i),
		.snoop_ack_o(snoop_ack_o), .pipeline_stall_o(pipeline_stall_o), .doze_o(doze_o),
		.halt_o(halt_o), .slow_clock_divider_o(slow_clock_divider_o),
		.icache_on_o(icache_on_o), .dcache_on_o(dcache_on_o),
		.dcache_burst_select_o(dcache_burst_select_o),
		.ifetch_burst_length_o(ifetch_burst_length_o),
		.dfill_burst_length_o(dfill_burst_length_o)
	);
	// ****************************************
	// Helpers
	// ****************************************
	initial forever #2.5 clk_i = ~clk_i;
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One access, held until ack or err is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, s, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		rd = wb_dat_o;
		er = wb_err_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		tally_and_finish();
	end
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		ticks(5);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			wb(1'b1, 8'h03, rows[i][0], 4'hf);
			wb(1'b0, 8'h03, 32'h0, 4'hf);
			chk("cfg", rows[i][1], rd);
			chk("outs", {rows[i][0][11:10], rows[i][0][6:0]}, {slow_clock_divider_o,
				dcache_burst_select_o, icache_on_o, dcache_on_o, ifetch_burst_length_o,
				dfill_burst_length_o});
		end
		wb(1'b1, 8'h03, 32'h0, 4'h1);
		wb(1'b0, 8'h03, 32'h0, 4'hf);
		chk("sel", 32'h00130400, rd);
		wb(1'b0, 8'h0f, 32'h0, 4'hf);
		chk("rev", 32'h00003c07, rd);
		wb(1'b1, 8'h0f, 32'hffffffff, 4'hf);
		wb(1'b0, 8'h0f, 32'h0, 4'hf);
		chk("rev ro", 32'h00003c07, rd);
		wb(1'b0, 8'h20, 32'h0, 4'hf);
		chk("unmapped", 32'h1, er);
		wb(1'b1, 8'h03, 32'h230, 4'hf);
		chk("doze", 32'h3, {doze_o, pipeline_stall_o});
		wb(1'b0, 8'h10, 32'h0, 4'hf);
		chk("pwr doze", 32'h3, rd);
		snoop_req_i <= 1'b1;
		ticks(2);
		chk("doze snoop", 32'h1, snoop_ack_o);
		irq_i <= 1'b1;
		ticks(1);
		irq_i <= 1'b0;
		ticks(1);
		chk("doze wake", 32'h0, {doze_o, pipeline_stall_o});
		wb(1'b1, 8'h03, 32'h130, 4'hf);
		chk("halt", 32'h3, {halt_o, pipeline_stall_o});
		ticks(1);
		chk("halt snoop", 32'h0, snoop_ack_o);
		nmi_i <= 1'b1;
		ticks(1);
		{nmi_i, snoop_req_i} <= 2'b00;
		ticks(1);
		chk("halt wake", 32'h0, {halt_o, pipeline_stall_o});
		bus_busy_i <= 1'b1;
		wb(1'b1, 8'h03, 32'h0, 4'hf);
		ticks(3);
		chk("busy hold", 32'h3, {icache_on_o, dcache_on_o});
		wb(1'b0, 8'h10, 32'h0, 4'hf);
		chk("pwr busy", 32'h6, rd);
		bus_busy_i <= 1'b0;
		ticks(3);
		chk("busy done", 32'h0, {icache_on_o, dcache_on_o});
		wb(1'b1, 8'h03, 32'h4b0, 4'hf);
		ticks(2);
		chk("lock store", 32'h1, slow_clock_divider_o);
		wb(1'b1, 8'h03, 32'h0, 4'hf);
		wb(1'b0, 8'h03, 32'h0, 4'hf);
		chk("locked", 32'h001304b0, rd);
		rst_i <= 1'b1;
		ticks(5);
		rst_i <= 1'b0;
		wb(1'b0, 8'h03, 32'h0, 4'hf);
		chk("cfg reset", 32'h00130030, rd);
		wb(1'b1, 8'h03, 32'h0, 4'hf);
		wb(1'b0, 8'h03, 32'h0, 4'hf);
		chk("unlocked", 32'h00130000, rd);
		tally_and_finish();
	end
endmodule
`default_nettype wire
